// ==== logic/tcc_pkg.sv ====
// Operation
// [RL1] Counter seen as two byte locations
// [RL2] High location reaches holding byte only
// [RL3] Low read loads, low write commits
// [RL4] One holding byte shared by all
// [RL5] Software masks interrupts during pairs
// [RL6] Clock select zero stops counting
// [RL7] CPU count write beats counting
// [RL8] Tick clears, increments or decrements
// [RL9] Overflow flag per mode, interrupt capable
// [RL10] Selected edge copies count to capture
// [RL11] Capture flag set with copy
// [RL12] Flag cleared by service or one
// [RL13] Capture low read feeds holding byte
// [RL14] Capture writable only in top modes
// [RL15] Software writes high before low
// [RL16] Select bit routes comparator output
// [RL17] Source switch may capture; clear flag
// [RL18] Filter changes after four equal samples
// [RL19] Filter adds four system cycles
// [RL20] Capture off in capture-top modes
// [RL21] Pin driven by software captures too
// [RL22] New capture overwrites old value
// [RL23] Software flips edge for duty cycle
// [RL24] Bottom is zero, maximum all ones
// [RL25] Top fixed, compare or capture value
// [RL26] Edge bit picks rising or falling
package tcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP_LO = 8'h10;
  localparam logic [7:0] OFS_CAP_HI = 8'h14;
  localparam logic [7:0] OFS_CMP_LO = 8'h18;
  localparam logic [7:0] OFS_CMP_HI = 8'h1C;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h28;
  // Field positions
  localparam int CA_WGM = 0;
  localparam int CB_CS = 0;
  localparam int CB_WGM = 3;
  localparam int CB_EDGE = 6;
  localparam int CB_FILT = 7;
  localparam int FL_OVF = 0;
  localparam int FL_CAP = 1;
  localparam int CC_SEL = 0;
  // Reset value of all state
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Count landmarks
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // Filter depth in system clock samples
  localparam int FILT_SAMPLES = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {DIR_UP, DIR_DOWN} tcc_dir_t;
  typedef enum logic [1:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_DUAL} tcc_kind_t;

  // Counting style of a waveform mode
  function automatic tcc_kind_t mode_kind(input logic [3:0] m);
    case (m)
      4'h4, 4'hC: mode_kind = KIND_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_kind = KIND_FAST;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: mode_kind = KIND_DUAL;
      default: mode_kind = KIND_NORMAL;
    endcase
  endfunction

  // Modes whose top is the capture register
  function automatic logic icr_top(input logic [3:0] m);
    case (m)
      4'h8, 4'hA, 4'hC, 4'hE: icr_top = 1'b1;
      default: icr_top = 1'b0;
    endcase
  endfunction

  // Top value of a waveform mode
  function automatic logic [15:0] mode_top(input logic [3:0] m,
                                           input logic [15:0] icr,
                                           input logic [15:0] ocr);
    if (icr_top(m)) begin
      mode_top = icr;
    end else begin
      case (m)
        4'h1, 4'h5: mode_top = TOP_8;
        4'h2, 4'h6: mode_top = TOP_9;
        4'h3, 4'h7: mode_top = TOP_10;
        4'h4, 4'h9, 4'hB, 4'hF: mode_top = ocr;
        default: mode_top = CNT_MAX;
      endcase
    end
  endfunction
endpackage

// ==== logic/tcc_noise_filter.sv ====
`timescale 1ns/100ps
module tcc_noise_filter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw and filtered level
  input wire logic sample_in,
  output logic filt_out
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [FILT_SAMPLES-1:0] hist;
    logic out;
  } tcc_filt_t;

  tcc_filt_t s_reg;
  tcc_filt_t s_next;

  // Output follows only a unanimous history
  always_comb begin
    s_next = s_reg;
    s_next.hist = {s_reg.hist[FILT_SAMPLES-2:0], sample_in};
    if (&s_reg.hist) begin
      s_next.out = 1'b1; // [RL18]
    end else if (~|s_reg.hist) begin
      s_next.out = 1'b0; // [RL18]
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign filt_out = s_reg.out;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  filt_agree_a: assert property ( // [RL18]
    $changed(s_reg.out) |-> $past(s_reg.hist) == {FILT_SAMPLES{s_reg.out}})
    else $error("filter output changed without four equal samples");
endmodule

// ==== logic/tcc_timer16.sv ====
`timescale 1ns/100ps
module tcc_timer16 (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Prescaled tick and capture sources
  input wire logic timer_tick,
  input wire logic capture_pin,
  input wire logic comparator_output,
  // Interrupt requests and service acknowledges
  output logic overflow_irq,
  output logic capture_irq,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  // Count landmarks
  output logic [15:0] count_value,
  output logic count_bottom,
  output logic count_max,
  output logic count_top
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [3:0] wgm;
    logic [2:0] cs;
    logic edge_rise;
    logic filt_en;
    logic cmp_sel;
    logic ovf_ie;
    logic cap_ie;
    logic ovf_flag;
    logic cap_flag;
    logic [7:0] temp;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] cmpa;
    tcc_dir_t dir;
    logic raw_smp;
    logic src_prev;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } tcc_state_t;

  tcc_state_t s_reg;
  tcc_state_t s_next;

  logic [15:0] top;
  tcc_kind_t kind;
  logic advance;
  logic ovf_set;
  logic cap_on;
  logic cap_src;
  logic filt_lvl;
  logic cap_lvl;
  logic cap_evt;
  logic do_write;
  logic do_read;
  logic ovf_clr;
  logic cap_clr;

  // Source select ahead of the filter; a software-driven pin level counts too
  assign cap_src = s_reg.cmp_sel ? comparator_output : capture_pin; // [RL16] [RL21]

  tcc_noise_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_in(cap_src),
    .filt_out(filt_lvl)
  );

  // Mode decode and edge detection
  assign kind = mode_kind(s_reg.wgm);
  assign top = mode_top(s_reg.wgm, s_reg.capture, s_reg.cmpa); // [RL25]
  assign advance = timer_tick && (s_reg.cs != 3'h0); // [RL6]
  assign cap_on = !icr_top(s_reg.wgm); // [RL20]
  assign cap_lvl = s_reg.filt_en ? filt_lvl : s_reg.raw_smp; // [RL19]
  assign cap_evt = cap_on && (s_reg.edge_rise ? (cap_lvl && !s_reg.src_prev)
                                              : (!cap_lvl && s_reg.src_prev)); // [RL26]
  assign do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
  assign do_read = s_axi_arvalid && !s_reg.rvalid;

  // Bus handshakes and outputs
  assign s_axi_awready = !s_reg.aw_full;
  assign s_axi_wready = !s_reg.w_full;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = {24'h000000, s_reg.rdata};
  assign overflow_irq = s_reg.ovf_flag && s_reg.ovf_ie; // [RL9]
  assign capture_irq = s_reg.cap_flag && s_reg.cap_ie; // [RL12]
  assign count_value = s_reg.count;
  assign count_bottom = s_reg.count == CNT_BOTTOM; // [RL24]
  assign count_max = s_reg.count == CNT_MAX; // [RL24]
  assign count_top = s_reg.count == top;

  // Next state: counting, capture, then bus side effects
  always_comb begin
    s_next = s_reg;
    ovf_set = 1'b0;
    ovf_clr = overflow_irq_ack;
    cap_clr = capture_irq_ack; // [RL12]
    s_next.raw_smp = cap_src;
    s_next.src_prev = cap_lvl; // A source switch can look like an edge [RL17]
    // Counter sequence per mode
    if (advance) begin
      case (kind)
        KIND_NORMAL: begin
          s_next.count = s_reg.count + 16'h0001; // [RL8]
          ovf_set = s_reg.count == CNT_MAX; // [RL9]
        end
        KIND_CTC: begin
          if (s_reg.count == top) begin
            s_next.count = CNT_BOTTOM; // [RL8]
          end else begin
            s_next.count = s_reg.count + 16'h0001;
          end
          ovf_set = s_reg.count == CNT_MAX;
        end
        KIND_FAST: begin
          if (s_reg.count >= top) begin
            s_next.count = CNT_BOTTOM;
            ovf_set = 1'b1; // [RL9]
          end else begin
            s_next.count = s_reg.count + 16'h0001;
          end
        end
        KIND_DUAL: begin
          if (s_reg.dir == DIR_UP) begin
            if (s_reg.count >= top) begin
              s_next.dir = DIR_DOWN;
              s_next.count = s_reg.count - 16'h0001; // [RL8]
            end else begin
              s_next.count = s_reg.count + 16'h0001;
            end
          end else if (s_reg.count == CNT_BOTTOM) begin
            s_next.dir = DIR_UP;
            s_next.count = s_reg.count + 16'h0001;
            ovf_set = 1'b1; // [RL9]
          end else begin
            s_next.count = s_reg.count - 16'h0001;
          end
        end
        default: s_next.count = s_reg.count;
      endcase
    end
    // Capture overwrites any unread value
    if (cap_evt) begin
      s_next.capture = s_reg.count; // [RL10] [RL22]
    end
    // Write address and data are taken in either order
    if (s_axi_awvalid && !s_reg.aw_full) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_full) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (do_write) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (s_reg.w_lane0) begin
        case ({s_reg.aw_addr[7:2], 2'b00})
          OFS_CTRL_A: s_next.wgm[1:0] = s_reg.w_data[CA_WGM +: 2];
          OFS_CTRL_B: begin
            s_next.cs = s_reg.w_data[CB_CS +: 3];
            s_next.wgm[3:2] = s_reg.w_data[CB_WGM +: 2];
            s_next.edge_rise = s_reg.w_data[CB_EDGE];
            s_next.filt_en = s_reg.w_data[CB_FILT];
          end
          OFS_CNT_LO: begin
            s_next.count = {s_reg.temp, s_reg.w_data}; // [RL3] [RL7]
            s_next.dir = s_reg.dir;
          end
          OFS_CNT_HI, OFS_CAP_HI, OFS_CMP_HI: s_next.temp = s_reg.w_data; // [RL2] [RL4]
          OFS_CAP_LO: begin
            if (icr_top(s_reg.wgm)) begin
              s_next.capture = {s_reg.temp, s_reg.w_data}; // [RL14]
            end
          end
          OFS_CMP_LO: s_next.cmpa = {s_reg.temp, s_reg.w_data};
          OFS_FLAGS: begin
            ovf_clr = ovf_clr || s_reg.w_data[FL_OVF];
            cap_clr = cap_clr || s_reg.w_data[FL_CAP]; // [RL12]
          end
          OFS_IRQ_EN: begin
            s_next.ovf_ie = s_reg.w_data[FL_OVF];
            s_next.cap_ie = s_reg.w_data[FL_CAP];
          end
          OFS_CMP_CTRL: s_next.cmp_sel = s_reg.w_data[CC_SEL]; // [RL16]
          default: s_next.bresp = RESP_SLVERR;
        endcase
      end
    end
    // Flags: a setting event wins over a clear
    s_next.ovf_flag = (s_reg.ovf_flag && !ovf_clr) || ovf_set; // [RL9]
    s_next.cap_flag = (s_reg.cap_flag && !cap_clr) || cap_evt; // [RL11]
    // Read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (do_read) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = RST_BYTE;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL_A: s_next.rdata[CA_WGM +: 2] = s_reg.wgm[1:0];
        OFS_CTRL_B: begin
          s_next.rdata[CB_CS +: 3] = s_reg.cs;
          s_next.rdata[CB_WGM +: 2] = s_reg.wgm[3:2];
          s_next.rdata[CB_EDGE] = s_reg.edge_rise;
          s_next.rdata[CB_FILT] = s_reg.filt_en;
        end
        OFS_CNT_LO: begin
          s_next.rdata = s_reg.count[7:0];
          s_next.temp = s_reg.count[15:8]; // [RL3] [RL1]
        end
        OFS_CNT_HI, OFS_CAP_HI: s_next.rdata = s_reg.temp; // [RL2] [RL13]
        OFS_CAP_LO: begin
          s_next.rdata = s_reg.capture[7:0];
          s_next.temp = s_reg.capture[15:8]; // [RL13]
        end
        OFS_CMP_LO: s_next.rdata = s_reg.cmpa[7:0];
        OFS_CMP_HI: s_next.rdata = s_reg.cmpa[15:8];
        OFS_FLAGS: begin
          s_next.rdata[FL_OVF] = s_reg.ovf_flag;
          s_next.rdata[FL_CAP] = s_reg.cap_flag;
        end
        OFS_IRQ_EN: begin
          s_next.rdata[FL_OVF] = s_reg.ovf_ie;
          s_next.rdata[FL_CAP] = s_reg.cap_ie;
        end
        OFS_CMP_CTRL: s_next.rdata[CC_SEL] = s_reg.cmp_sel;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helper that marks a count-low write in the current cycle
  logic cnt_wr;
  assign cnt_wr = do_write && s_reg.w_lane0 &&
                  ({s_reg.aw_addr[7:2], 2'b00} == OFS_CNT_LO);

  stop_hold_a: assert property ( // [RL6]
    (s_reg.cs == 3'h0 && !cnt_wr) |=> $stable(s_reg.count))
    else $error("counter moved with clock select zero");

  cpu_wins_a: assert property ( // [RL7]
    cnt_wr |=> s_reg.count == {$past(s_reg.temp), $past(s_reg.w_data)})
    else $error("count write lost to counting");

  norm_step_a: assert property ( // [RL8]
    (advance && kind == KIND_NORMAL && !cnt_wr)
      |=> s_reg.count == $past(s_reg.count) + 16'h0001)
    else $error("normal mode did not increment");

  ovf_wrap_a: assert property ( // [RL9]
    (advance && kind == KIND_NORMAL && s_reg.count == CNT_MAX) |=> s_reg.ovf_flag)
    else $error("overflow flag missing at wrap");

  cap_copy_a: assert property ( // [RL10]
    cap_evt |=> s_reg.capture == $past(s_reg.count))
    else $error("capture did not copy count");

  cap_flag_a: assert property ( // [RL11]
    cap_evt |=> s_reg.cap_flag && (s_reg.capture == $past(s_reg.count)))
    else $error("capture flag not set with copy");

  ack_clear_a: assert property ( // [RL12]
    (capture_irq_ack && !cap_evt) |=> !s_reg.cap_flag)
    else $error("capture flag not cleared by service");

  cap_off_a: assert property ( // [RL20]
    icr_top(s_reg.wgm) |=> !$rose(s_reg.cap_flag))
    else $error("capture fired in capture-top mode");

  tmp_load_a: assert property ( // [RL3]
    (do_read && {s_axi_araddr[7:2], 2'b00} == OFS_CNT_LO)
      |=> s_reg.temp == $past(s_reg.count[15:8]))
    else $error("count low read did not load holding byte");

  src_sel_a: assert property ( // [RL16]
    s_reg.cmp_sel |=> s_reg.raw_smp == $past(comparator_output))
    else $error("comparator output not routed to capture");
endmodule

// ==== verif/tcc_tick_src.sv ====
`timescale 1ns/100ps
module tcc_tick_src (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Burst request
  input wire logic go,
  input wire logic [7:0] n,
  // Tick out
  output logic timer_tick,
  output logic busy
);
  logic [7:0] left_reg;
  logic ph_reg;
  // One-cycle ticks with an idle cycle between, so counts are exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= 8'h00;
      ph_reg <= 1'b0;
      timer_tick <= 1'b0;
    end else if (go) begin
      left_reg <= n;
      ph_reg <= 1'b0;
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= (left_reg != 8'h00) && !ph_reg;
      if ((left_reg != 8'h00) && !ph_reg) begin
        left_reg <= left_reg - 8'h01;
      end
      ph_reg <= !ph_reg;
    end
  end
  // Busy until the last tick has left
  assign busy = (left_reg != 8'h00) || timer_tick;
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import tcc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic timer_tick;
  logic capture_pin = 1'b0;
  logic comparator_output = 1'b0;
  logic overflow_irq;
  logic capture_irq;
  logic overflow_irq_ack = 1'b0;
  logic capture_irq_ack = 1'b0;
  logic [15:0] count_value;
  logic count_bottom;
  logic count_max;
  logic count_top;
  logic tk_go = 1'b0;
  logic [7:0] tk_n = 8'h00;
  logic tk_busy;
  logic [1:0] resp;
  logic [7:0] b;
  logic [15:0] v;
  int error_cnt = 0;
  int checks = 0;

  // Clock at 50 MHz
  always #10 aclk = ~aclk;

  tcc_timer16 DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_tick(timer_tick),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
    .count_value(count_value), .count_bottom(count_bottom), .count_max(count_max),
    .count_top(count_top));

  tcc_tick_src tick_src (.aclk(aclk), .aresetn(aresetn), .go(tk_go), .n(tk_n),
    .timer_tick(timer_tick), .busy(tk_busy));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // AXI4-Lite write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && (s_axi_awready === 1'b1);
      tw = pw && (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // AXI4-Lite read of one byte location
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Sixteen-bit pairs: write high then low, read low then high
  task automatic wr16(input logic [7:0] lo, input logic [15:0] x);
    wr(lo + 8'h04, x[15:8]);
    wr(lo, x[7:0]);
  endtask

  task automatic rd16(input logic [7:0] lo, output logic [15:0] x);
    logic [7:0] l;
    logic [7:0] h;
    rd(lo, l); // Nothing else touches the holding byte in between
    rd(lo + 8'h04, h);
    x = {h, l};
  endtask

  // Ask the tick source for n ticks and wait until they landed
  task automatic burst(input logic [7:0] k);
    @(posedge aclk);
    tk_n <= k;
    tk_go <= 1'b1;
    @(posedge aclk);
    tk_go <= 1'b0;
    do @(negedge aclk); while (tk_busy);
    repeat (2) @(negedge aclk);
  endtask

  // Drive capture sources and let the edge settle
  task automatic src(input logic p, input logic c);
    @(posedge aclk);
    capture_pin <= p;
    comparator_output <= c;
    repeat (12) @(posedge aclk);
  endtask

  task automatic conclude();
    $display("Errors %0d, checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end

  // Test sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL_B, b);
    chk(b, 8'h00);
    rd(8'h2C, b);
    chk(resp, RESP_SLVERR);
    wr(8'h30, 8'h5A);
    chk(resp, RESP_SLVERR);
    wr16(OFS_CNT_LO, 16'h01FF);
    @(negedge aclk);
    chk(count_value, 16'h01FF);
    burst(8'd3);
    chk(count_value, 16'h01FF);
    rd16(OFS_CNT_LO, v);
    chk(v, 16'h01FF);
    wr(OFS_CNT_HI, 8'h12);
    wr(OFS_CNT_LO, 8'h34);
    wr(OFS_CMP_LO, 8'h56);
    wr(OFS_CNT_HI, 8'h77);
    @(negedge aclk);
    chk(count_value, 16'h1234);
    rd(OFS_CMP_LO, b);
    rd(OFS_CMP_HI, b);
    chk(b, 8'h12);
    // Normal mode wrap and overflow
    wr16(OFS_CNT_LO, 16'hFFFE);
    wr(OFS_CTRL_B, 8'h01);
    burst(8'd1);
    chk(count_max, 1'b1);
    burst(8'd1);
    chk(count_bottom, 1'b1);
    chk(count_value, 16'h0000);
    rd(OFS_FLAGS, b);
    chk(b, 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    @(negedge aclk);
    chk(overflow_irq, 1'b1);
    @(posedge aclk);
    overflow_irq_ack <= 1'b1;
    @(posedge aclk);
    overflow_irq_ack <= 1'b0;
    @(negedge aclk);
    chk(overflow_irq, 1'b0);
    // Clear at top of compare A, then fixed 8-bit top
    wr16(OFS_CMP_LO, 16'h0002);
    wr16(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL_B, 8'h09);
    burst(8'd2);
    chk(count_top, 1'b1);
    burst(8'd1);
    chk(count_value, 16'h0000);
    wr(OFS_CTRL_A, 8'h01);
    wr16(OFS_CNT_LO, 16'h00FE);
    burst(8'd1);
    chk(count_top, 1'b1);
    chk(count_value, 16'h00FF);
    burst(8'd1);
    chk(count_value, 16'h0000);
    // Up-down count to fixed 8-bit top, overflow at bottom
    wr(OFS_CTRL_B, 8'h01);
    wr16(OFS_CNT_LO, 16'h00FE);
    wr(OFS_FLAGS, 8'h01);
    burst(8'd2);
    chk(count_value, 16'h00FE);
    wr16(OFS_CNT_LO, 16'h0001);
    burst(8'd2);
    chk(count_value, 16'h0001);
    rd(OFS_FLAGS, b);
    chk(b, 8'h01);
    // Capture on rising edge of the pin
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CTRL_B, 8'h40);
    wr16(OFS_CNT_LO, 16'h1234);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_IRQ_EN, 8'h02);
    src(1'b1, 1'b0);
    chk(capture_irq, 1'b1);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h1234);
    wr(OFS_FLAGS, 8'h02);
    @(negedge aclk);
    chk(capture_irq, 1'b0);
    src(1'b0, 1'b0);
    rd(OFS_FLAGS, b);
    chk(b, 8'h00);
    wr16(OFS_CNT_LO, 16'h5678);
    src(1'b1, 1'b0);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h5678);
    // Edge flipped to falling for duty cycle
    wr16(OFS_CNT_LO, 16'h4444);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_FLAGS, 8'h02);
    src(1'b0, 1'b0);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h4444);
    chk(capture_irq, 1'b1);
    @(posedge aclk);
    capture_irq_ack <= 1'b1;
    @(posedge aclk);
    capture_irq_ack <= 1'b0;
    @(negedge aclk);
    chk(capture_irq, 1'b0);
    // Comparator as capture source
    wr16(OFS_CNT_LO, 16'h2222);
    wr(OFS_CMP_CTRL, 8'h01);
    wr(OFS_FLAGS, 8'h02);
    src(1'b1, 1'b0);
    src(1'b0, 1'b0);
    rd(OFS_FLAGS, b);
    chk(b, 8'h00);
    src(1'b0, 1'b1);
    src(1'b0, 1'b0);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h2222);
    // Filter rejects a three-sample glitch
    wr(OFS_CMP_CTRL, 8'h00);
    wr(OFS_CTRL_B, 8'hC0);
    wr(OFS_FLAGS, 8'h02);
    @(posedge aclk);
    capture_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    capture_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    rd(OFS_FLAGS, b);
    chk(b, 8'h00);
    src(1'b1, 1'b0);
    rd(OFS_FLAGS, b);
    chk(b, 8'h02);
    // Capture writes ignored outside capture-top modes
    wr(OFS_CTRL_B, 8'h40);
    wr16(OFS_CAP_LO, 16'h0111);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h2222);
    wr(OFS_CTRL_B, 8'h58);
    wr16(OFS_CAP_LO, 16'h0ABC);
    rd16(OFS_CAP_LO, v);
    chk(v, 16'h0ABC);
    wr(OFS_FLAGS, 8'h02);
    src(1'b0, 1'b0);
    src(1'b1, 1'b0);
    rd(OFS_FLAGS, b);
    chk(b, 8'h00);
    conclude();
  end
endmodule
